// ===== hdl/uie_consts.vh
// constants for the uart interrupt enable logic block
`ifndef UIE_CONSTS_VH
`define UIE_CONSTS_VH

// register byte offsets on the axi4-lite bus
`define UIE_OFS_IMR 8'h00
`define UIE_OFS_QCR 8'h04
`define UIE_OFS_ICR 8'h08
`define UIE_OFS_LCR 8'h0C
`define UIE_OFS_MCR 8'h10

// reset values
`define UIE_IMR_RESET 8'h00
`define UIE_QCR_RESET 1'h0

// interrupt mask register bit positions
`define UIE_IMR_RX 0
`define UIE_IMR_TX 1
`define UIE_IMR_LINE 2
`define UIE_IMR_MODEM 3
`define UIE_IMR_SLEEP 4
`define UIE_IMR_XOFF 5
`define UIE_IMR_RTS 6
`define UIE_IMR_CTS 7

// queue control register: fifo enable bit
`define UIE_QCR_FIFO_EN 0

// interrupt cause codes, highest priority first
`define UIE_CAUSE_LINE 6'h06
`define UIE_CAUSE_RX 6'h04
`define UIE_CAUSE_TX 6'h02
`define UIE_CAUSE_MODEM 6'h00
`define UIE_CAUSE_XOFF 6'h10
`define UIE_CAUSE_EDGE 6'h20
`define UIE_CAUSE_NONE 6'h01

// axi response codes
`define UIE_RESP_OKAY 2'h0
`define UIE_RESP_SLVERR 2'h2

`endif

// ===== hdl/uie_edge_detect.v
// rising edge detector with optional two-stage pin synchroniser
`timescale 1ns/1ps
`default_nettype none

module uie_edge_detect #(
  parameter SYNC = 1
) (
  input wire ref_clk, // block clock
  input wire resetn, // async reset, active low
  input wire level_in, // level to watch
  output reg rise // one-cycle pulse on 0 to 1
);

  wire level_s;
  reg prev;

  generate
    if (SYNC != 0)
    begin : g_sync
      reg meta;
      reg stable;
      // first stage feeds only the second stage; both start at the
      // idle high level of an active-low line, so release makes no edge
      always @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          meta <= 1'h1;
          stable <= 1'h1;
        end
        else
        begin
          meta <= level_in;
          stable <= meta;
        end
      end
      assign level_s = stable;
    end
    else
    begin : g_direct
      assign level_s = level_in;
    end
  endgenerate

  // registered pulse so the consumer sees a clean flop output
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prev <= 1'h1;
      rise <= 1'h0;
    end
    else
    begin
      prev <= level_s;
      rise <= level_s & ~prev;
    end
  end

endmodule
`default_nettype wire

// ===== hdl/uie_interrupt_enable.v
// uart interrupt enable, masking and line status logic with axi4-lite
`timescale 1ns/1ps
`default_nettype none
`include "uie_consts.vh"

module uie_interrupt_enable #(
  parameter ADDR_W = 8,
  parameter CNT_W = 8
) (
  input wire ref_clk, // 50 mhz block clock
  input wire resetn, // async reset, active low
  input wire [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [ADDR_W-1:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire cts_n_pin, // clear-to-send pin, asynchronous
  input wire rts_n_level, // request-to-send output as driven
  input wire xoff_received, // pulse: xoff character matched
  input wire [3:0] modem_change, // modem condition change flags
  input wire [3:0] rx_error, // overrun, parity, framing, break
  input wire rx_char_loaded, // pulse: char moved from receive shifter
  input wire rx_fifo_empty, // receive fifo or holding reg empty
  input wire [CNT_W-1:0] rx_fifo_level, // receive fifo fill
  input wire [CNT_W-1:0] rx_trigger_level, // programmed trigger
  input wire rx_fifo_data_error, // some queued char carries an error
  input wire tx_fifo_empty, // transmit fifo or holding reg empty
  input wire tx_shifter_empty, // transmit shifter idle
  input wire tx_write, // pulse: host wrote transmit holding reg
  output reg fifo_enable, // both fifos enabled
  output reg sleep_enable, // sleep mode permitted
  output reg irq // interrupt output, active high
);

  reg [7:0] interrupt_mask_register;
  reg data_ready;
  reg tx_empty_prev;
  reg tx_pending;
  reg xoff_pending;
  reg cts_pending;
  reg rts_pending;
  reg [5:0] cause_code;
  reg aw_held;
  reg w_held;
  reg [ADDR_W-1:0] aw_addr;
  reg [7:0] w_byte;
  reg w_lane0;
  wire [1:0] edge_in;
  wire [1:0] edge_rise;
  wire [7:0] line_condition_register;
  wire [7:0] modem_condition_register;
  wire polled_mode;
  wire line_int;
  wire rx_int;
  wire tx_int;
  wire modem_int;
  wire xoff_int;
  wire cts_int;
  wire rts_int;
  wire rx_over_trigger;
  wire wr_fire;
  wire rd_fire;
  wire cause_read;
  reg [5:0] next_cause;
  reg [31:0] next_rdata;
  reg next_rd_err;

  // edge watchers: cts comes from a pin, rts is our own flop level
  assign edge_in = {rts_n_level, cts_n_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_edge
      uie_edge_detect #(
        .SYNC(gi == 0 ? 1 : 0)
      ) u_edge (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .level_in(edge_in[gi]),
        .rise(edge_rise[gi])
      );
    end
  endgenerate

  // polled mode: fifos on with the four classic enables all clear
  assign polled_mode = fifo_enable &
    (interrupt_mask_register[3:0] == 4'h0);

  // line status view composed from live queue and shifter state
  assign line_condition_register = {
    rx_fifo_data_error,
    tx_fifo_empty & tx_shifter_empty,
    tx_fifo_empty,
    rx_error,
    data_ready
  };
  assign modem_condition_register = {4'h0, modem_change};

  assign rx_over_trigger = (rx_fifo_level >= rx_trigger_level);

  // per-source gating by the mask register
  assign line_int = interrupt_mask_register[`UIE_IMR_LINE] &
    (|rx_error);
  assign rx_int = interrupt_mask_register[`UIE_IMR_RX] &
    (fifo_enable ? rx_over_trigger : data_ready);
  assign tx_int = interrupt_mask_register[`UIE_IMR_TX] &
    (fifo_enable ? tx_pending : tx_fifo_empty);
  assign modem_int = interrupt_mask_register[`UIE_IMR_MODEM] &
    (|modem_change);
  // extra sources are silenced too while polling is selected
  assign xoff_int = interrupt_mask_register[`UIE_IMR_XOFF] &
    xoff_pending & ~polled_mode;
  assign cts_int = interrupt_mask_register[`UIE_IMR_CTS] &
    cts_pending & ~polled_mode;
  assign rts_int = interrupt_mask_register[`UIE_IMR_RTS] &
    rts_pending & ~polled_mode;

  // priority encoder for the cause code
  always @*
  begin
    if (line_int)
      next_cause = `UIE_CAUSE_LINE;
    else if (rx_int)
      next_cause = `UIE_CAUSE_RX;
    else if (tx_int)
      next_cause = `UIE_CAUSE_TX;
    else if (modem_int)
      next_cause = `UIE_CAUSE_MODEM;
    else if (xoff_int)
      next_cause = `UIE_CAUSE_XOFF;
    else if (cts_int | rts_int)
      next_cause = `UIE_CAUSE_EDGE;
    else
      next_cause = `UIE_CAUSE_NONE;
  end

  // cause register and interrupt pin follow the sources one cycle late
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cause_code <= `UIE_CAUSE_NONE;
      irq <= 1'h0;
    end
    else
    begin
      cause_code <= next_cause;
      irq <= (next_cause != `UIE_CAUSE_NONE);
    end
  end

  // data ready: a new char wins over an empty indication in the same cycle
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      data_ready <= 1'h0;
    else if (rx_char_loaded)
      data_ready <= 1'h1;
    else if (rx_fifo_empty)
      data_ready <= 1'h0;
  end

  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign cause_read = rd_fire &
    (s_axi_araddr == `UIE_OFS_ICR);

  // transmit fifo drain flag; a fresh drain wins over any clear
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_empty_prev <= 1'h1;
      tx_pending <= 1'h0;
    end
    else
    begin
      tx_empty_prev <= tx_fifo_empty;
      if (fifo_enable & tx_fifo_empty & ~tx_empty_prev)
        tx_pending <= 1'h1;
      else if (tx_write | ~fifo_enable)
        tx_pending <= 1'h0;
      else if (cause_read & (cause_code == `UIE_CAUSE_TX))
        tx_pending <= 1'h0;
    end
  end

  // sticky edge and xoff flags, cleared by reading their cause code
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      xoff_pending <= 1'h0;
      cts_pending <= 1'h0;
      rts_pending <= 1'h0;
    end
    else
    begin
      if (xoff_received & interrupt_mask_register[`UIE_IMR_XOFF])
        xoff_pending <= 1'h1;
      else if (cause_read & (cause_code == `UIE_CAUSE_XOFF))
        xoff_pending <= 1'h0;
      if (edge_rise[0] & interrupt_mask_register[`UIE_IMR_CTS])
        cts_pending <= 1'h1;
      else if (cause_read & (cause_code == `UIE_CAUSE_EDGE))
        cts_pending <= 1'h0;
      if (edge_rise[1] & interrupt_mask_register[`UIE_IMR_RTS])
        rts_pending <= 1'h1;
      else if (cause_read & (cause_code == `UIE_CAUSE_EDGE))
        rts_pending <= 1'h0;
    end
  end

  // write channel: address and data are taken independently
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held <= 1'h0;
      w_held <= 1'h0;
      aw_addr <= {ADDR_W{1'b0}};
      w_byte <= 8'h00;
      w_lane0 <= 1'h0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held <= 1'h1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held <= 1'h0;
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held <= 1'h1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      else if (wr_fire)
        w_held <= 1'h0;
    end
  end

  // register writes; only byte lane 0 carries register bits
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      interrupt_mask_register <= `UIE_IMR_RESET;
      fifo_enable <= `UIE_QCR_RESET;
      sleep_enable <= 1'h0;
    end
    else
    begin
      if (wr_fire & w_lane0 &
          (aw_addr == `UIE_OFS_IMR))
        interrupt_mask_register <= w_byte;
      if (wr_fire & w_lane0 &
          (aw_addr == `UIE_OFS_QCR))
        fifo_enable <= w_byte[`UIE_QCR_FIFO_EN];
      sleep_enable <= interrupt_mask_register[`UIE_IMR_SLEEP];
    end
  end

  // write response; unmapped or read-only addresses answer slverr
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= `UIE_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'h1;
      if ((aw_addr == `UIE_OFS_IMR) |
          (aw_addr == `UIE_OFS_QCR))
        s_axi_bresp <= `UIE_RESP_OKAY;
      else
        s_axi_bresp <= `UIE_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'h0;
  end

  // read mux; reserved bits read as zero
  always @*
  begin
    next_rdata = 32'h00000000;
    next_rd_err = 1'h0;
    case (s_axi_araddr)
      `UIE_OFS_IMR:
        next_rdata[7:0] = interrupt_mask_register;
      `UIE_OFS_QCR:
        next_rdata[0] = fifo_enable;
      `UIE_OFS_ICR:
        next_rdata[5:0] = cause_code;
      `UIE_OFS_LCR:
        next_rdata[7:0] = line_condition_register;
      `UIE_OFS_MCR:
        next_rdata[7:0] = modem_condition_register;
      default:
        next_rd_err = 1'h1;
    endcase
  end

  // one read outstanding: arready drops while data wait for rready
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `UIE_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'h1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rd_err ? `UIE_RESP_SLVERR : `UIE_RESP_OKAY;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'h0;
  end

endmodule
`default_nettype wire

// ===== testbench/uie_props.sv
// assertion checker for the uart interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module uie_props (
  input wire logic ref_clk, // clock
  input wire logic resetn, // reset
  input wire logic [7:0] s_axi_awaddr, // aw
  input wire logic s_axi_awvalid, // aw
  input wire logic s_axi_awready, // aw
  input wire logic [31:0] s_axi_wdata, // w
  input wire logic [3:0] s_axi_wstrb, // w
  input wire logic s_axi_wvalid, // w
  input wire logic s_axi_bvalid, // b
  input wire logic s_axi_bready, // b
  input wire logic s_axi_arvalid, // ar
  input wire logic s_axi_arready, // ar
  input wire logic s_axi_rvalid, // r
  input wire logic [3:0] rx_error, // errors
  input wire logic [3:0] modem_change, // modem
  input wire logic [7:0] rx_fifo_level, // fill
  input wire logic [7:0] rx_trigger_level, // trigger
  input wire logic tx_fifo_empty, // tx empty
  input wire logic fifo_enable, // fifos on
  input wire logic sleep_enable, // sleep
  input wire logic irq // interrupt
);
  reg [7:0] imr;
  reg [7:0] ad;
  reg [7:0] wd;
  reg ws;
  // mask shadow lags the real one until the answer is taken
  always @(posedge ref_clk or negedge resetn)
    if (!resetn)
      imr <= 8'h00;
    else if (s_axi_bvalid && s_axi_bready && ad == 8'h00 && ws)
      imr <= wd;
  // last offered write address and data
  always @(posedge ref_clk)
  begin
    if (s_axi_awvalid)
      ad <= s_axi_awaddr;
    if (s_axi_wvalid)
      wd <= s_axi_wdata[7:0];
    if (s_axi_wvalid)
      ws <= s_axi_wstrb[0];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  rst_quiet_a: assert property ($rose(resetn) |-> !irq && !sleep_enable
    && !fifo_enable) else $error("outputs not clear after reset");
  sleep_copy_a: assert property (!s_axi_bvalid |->
    sleep_enable == imr[4]) else $error("sleep enable differs from mask");
  line_irq_a: assert property (!s_axi_bvalid && imr[2] && |rx_error
    |=> irq) else $error("line status irq missing");
  modem_irq_a: assert property (!s_axi_bvalid && imr[3] && |modem_change
    |=> irq) else $error("modem irq missing");
  tx_irq_a: assert property (!s_axi_bvalid && imr[1] && !fifo_enable
    && tx_fifo_empty |=> irq) else $error("tx irq missing");
  rx_fifo_a: assert property (!s_axi_bvalid && imr[0] && fifo_enable
    && rx_fifo_level >= rx_trigger_level |=> irq)
    else $error("rx irq missing");
  polled_a: assert property (!s_axi_bvalid && fifo_enable
    && imr[3:0] == 4'h0 |=> !irq) else $error("irq in polled mode");
  rd_answer_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read not answered");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
endmodule
bind uie_interrupt_enable uie_props u_props (.*);
`default_nettype wire

// ===== testbench/uie_host.sv
// axi4-lite host model driving the register bus
`timescale 1ns/1ps
`default_nettype none
module uie_host (
  input wire logic ref_clk, // clock
  output logic [7:0] s_axi_awaddr, // aw
  output logic s_axi_awvalid, // aw
  input wire logic s_axi_awready, // aw
  output logic [31:0] s_axi_wdata, // w
  output logic s_axi_wvalid, // w
  input wire logic s_axi_wready, // w
  input wire logic [1:0] s_axi_bresp, // b
  input wire logic s_axi_bvalid, // b
  output logic [7:0] s_axi_araddr, // ar
  output logic s_axi_arvalid, // ar
  input wire logic s_axi_arready, // ar
  input wire logic [31:0] s_axi_rdata, // r
  input wire logic [1:0] s_axi_rresp, // r
  input wire logic s_axi_rvalid // r
);
  // bus idle from time zero
  initial
  begin
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
  end
  // address and data offered together, each released once taken
  task wr(input [7:0] a, input [31:0] v, output [1:0] r);
  begin
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    @(posedge ref_clk);
    while (!s_axi_bvalid)
    begin
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      @(posedge ref_clk);
    end
    r = s_axi_bresp;
  end
  endtask
  // no fixed latency assumed: wait for the answer itself
  task rd(input [7:0] a, output [31:0] v, output [1:0] r);
  begin
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge ref_clk);
    while (!s_axi_rvalid)
    begin
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      @(posedge ref_clk);
    end
    v = s_axi_rdata;
    r = s_axi_rresp;
  end
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_uart_interrupt_enable_logic.sv
// self-checking bench for the uart interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module tb_uart_interrupt_enable_logic;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  wire fifo_enable, sleep_enable, irq;
  // answers always accepted at once, full word strobes
  wire [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_bready = 1'b1;
  wire s_axi_rready = 1'b1;
  reg ref_clk = 1'b0, resetn = 1'b0, cts_n_pin = 1'b0, rts_n_level = 1'b0;
  reg xoff_received = 1'b0, rx_char_loaded = 1'b0, rx_fifo_empty = 1'b1;
  reg rx_fifo_data_error = 1'b0, tx_fifo_empty = 1'b0;
  reg tx_shifter_empty = 1'b0, tx_write = 1'b0;
  reg [3:0] modem_change = 4'h0, rx_error = 4'h0;
  reg [7:0] rx_fifo_level = 8'h00, rx_trigger_level = 8'h01;
  reg [31:0] seed = 32'hBD369CD5;
  reg [31:0] d;
  reg [1:0] r;
  integer failures = 0, cmp_count = 0, tn = 0, i;
  uie_interrupt_enable uut (.*);
  uie_host host (.*);
  // 50 mhz clock
  always #10 ref_clk = ~ref_clk;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task ck(input [31:0] g, input [31:0] e);
  begin
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  end
  endtask
  task ckb(input g, input e);
  begin
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("[ERR] %0t flag %b expected %b", $time, g, e);
    end
  end
  endtask
  task rd(input [7:0] a, input [31:0] e);
  begin
    host.rd(a, d, r);
    ck(d, e);
  end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    host.wr(a, {24'h0, v}, r);
  endtask
  // pin sync adds a few cycles, so give the interrupt time to settle
  task ckirq(input e);
  begin
    repeat (6) @(posedge ref_clk);
    #1 ckb(irq, e);
    @(posedge ref_clk);
  end
  endtask
  task nxt;
  begin
    tn = tn + 1;
    $display("test %0d done", tn);
  end
  endtask
  task finish_test;
  begin
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    failures = failures + 1;
    finish_test;
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    repeat (4)
    begin
      seed = lfsr(seed);
      wr(8'h00, seed[7:0]);
      rd(8'h00, {24'h0, seed[7:0]});
      @(posedge ref_clk);
      ckb(sleep_enable, seed[4]);
    end
    host.wr(8'h14, 32'hFF, r);
    ck({30'h0, r}, 32'h2);
    host.wr(8'h08, 32'hFF, r);
    ck({30'h0, r}, 32'h2);
    host.rd(8'h14, d, r);
    ck({30'h0, r}, 32'h2);
    nxt;
    // status bits follow sources; data ready held until empty
    wr(8'h00, 8'h00);
    seed = lfsr(seed);
    rx_error <= seed[3:0] | 4'h1;
    {rx_fifo_empty, rx_char_loaded, tx_fifo_empty} <= 3'b011;
    {tx_shifter_empty, rx_fifo_data_error} <= 2'b11;
    @(posedge ref_clk);
    rx_char_loaded <= 1'b0;
    rd(8'h0C, {24'h0, 3'h7, seed[3:0] | 4'h1, 1'b1});
    {tx_shifter_empty, rx_fifo_data_error} <= 2'b00;
    rd(8'h0C, {24'h0, 3'h1, seed[3:0] | 4'h1, 1'b1});
    wr(8'h00, 8'h05);
    rd(8'h08, 32'h06);
    ckb(irq, 1'b1);
    rx_error <= 4'h0;
    ckirq(1'b1);
    rd(8'h08, 32'h04);
    rx_fifo_empty <= 1'b1;
    ckirq(1'b0);
    rd(8'h0C, 32'h20);
    nxt;
    // modem flags, then the non-queued transmit source
    wr(8'h00, 8'h08);
    modem_change <= seed[7:4] | 4'h8;
    ckirq(1'b1);
    rd(8'h10, {28'h0, seed[7:4] | 4'h8});
    rd(8'h08, 32'h00);
    modem_change <= 4'h0;
    ckirq(1'b0);
    wr(8'h00, 8'h02);
    ckirq(1'b1);
    rd(8'h08, 32'h02);
    tx_fifo_empty <= 1'b0;
    ckirq(1'b0);
    nxt;
    // xoff masked then enabled; cts edge then rts edge
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(8'h00, i ? 8'h20 : 8'h00);
      xoff_received <= 1'b1;
      @(posedge ref_clk);
      xoff_received <= 1'b0;
      ckirq(i == 1);
    end
    rd(8'h08, 32'h10);
    ckirq(1'b0);
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(8'h00, i ? 8'h40 : 8'h80);
      cts_n_pin <= 1'b1;
      rts_n_level <= i == 1;
      ckirq(1'b1);
      rd(8'h08, 32'h20);
      ckirq(1'b0);
    end
    nxt;
    // queued receive at and just below a random trigger
    wr(8'h04, 8'h01);
    ckb(fifo_enable, 1'b1);
    wr(8'h00, 8'h01);
    repeat (2)
    begin
      seed = lfsr(seed);
      rx_trigger_level <= seed[7:0] | 8'h01;
      rx_fifo_level <= seed[7:0] | 8'h01;
      ckirq(1'b1);
      rd(8'h08, 32'h04);
      rx_fifo_level <= (seed[7:0] | 8'h01) - 8'h01;
      ckirq(1'b0);
      rd(8'h08, 32'h01);
    end
    // queued transmit cleared by a cause read, then by a new write
    wr(8'h00, 8'h02);
    for (i = 0; i < 2; i = i + 1)
    begin
      tx_fifo_empty <= 1'b1;
      ckirq(1'b1);
      if (i)
        tx_write <= 1'b1;
      else
        rd(8'h08, 32'h02);
      tx_fifo_empty <= 1'b0;
      @(posedge ref_clk);
      tx_write <= 1'b0;
      ckirq(1'b0);
    end
    nxt;
    // polled mode: no interrupt, status only by polling
    wr(8'h00, 8'h20);
    xoff_received <= 1'b1;
    rx_error <= 4'h3;
    @(posedge ref_clk);
    xoff_received <= 1'b0;
    ckirq(1'b0);
    rd(8'h0C, 32'h06);
    nxt;
    finish_test;
  end
endmodule
`default_nettype wire
